// file: inc/lsp_regs.svh
// Constants of the legacy serial slave link and its master end.
// Assumes a 10 MHz ref_clk; included by the slave and master modules.
// Function
// - Master opens with start one, direction, address
// - Direction one reads, zero writes
// - Address set: status read, write ignored
// - Decode direction and address into four operations
// - One byte takes twelve clocks
// - One byte per transfer, MSB first
// - Trailing status bit: zero good, one retry
// - All pins launched and sampled on rising
// - Select stays high for whole transfer
// - Select low one clock after data transfers
// - Start is MOSI and select high
// - Read shifts transmit byte, then status bit
// - Read status zero pops, one means stale
// - Status bit holds one clock only
// - Read ends after twelve clocks, restart allowed
// - Write status follows the eighth data bit
// - Write status zero accepted, one dropped
// - Master checks status, repeats rejected writes; lsp_master only reports the status, the user repeats
// - Master polls transmit buffer with reads
// - Status byte layout: flags and enables
// - Status read trailing bit always zero
`ifndef LSP_REGS_SVH
`define LSP_REGS_SVH

`define LSP_CLK_PERIOD_NS   100
`define LSP_SCLK_PERIOD_NS  800
`define LSP_SCLK_HALF       ((`LSP_SCLK_PERIOD_NS / `LSP_CLK_PERIOD_NS) / 2)
`define LSP_LAUNCH_DLY      2
`define LSP_EDGE_RW         1
`define LSP_EDGE_ADDR       2
`define LSP_EDGE_DATA_FIRST 3
`define LSP_EDGE_DATA_LAST  10
`define LSP_EDGE_STATUS     11
`define LSP_XFER_EDGES      12
`define LSP_ST_RXF          0
`define LSP_ST_TXE          1
`define LSP_ST_RXIE         4
`define LSP_ST_TXIE         5
`define LSP_ST_RESET        8'h00

`endif

// file: inc/lsp_pkg.sv
// Types shared by both ends of the legacy serial link.
// Assumes nothing beyond a SystemVerilog compiler.
package lsp_pkg;
	typedef logic [7:0] lsp_byte_t;
	typedef enum logic [1:0] {LSP_S_IDLE, LSP_S_SETUP, LSP_S_XFER} lsp_slv_state_t;
	typedef enum logic [1:0] {LSP_M_IDLE, LSP_M_RUN, LSP_M_GAP} lsp_mst_state_t;
endpackage

// file: inc/lsp_if.sv
// Four-wire link between the master end and the slave end.
// Assumes the bench joins both ends through one instance.
interface lsp_if;
	logic sclk;
	logic ss;
	logic mosi;
	logic miso;
	modport dev (input sclk, input ss, input mosi, output miso);
	modport host (output sclk, output ss, output mosi, input miso);
endinterface

// file: core/lsp_slave.sv
// Slave end of the legacy serial link, plus a two-entry stream buffer.
// Assumes the link pins come from another domain; user streams run on ref_clk.
`include "lsp_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module lsp_buf2 #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// Drain side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	logic [W-1:0] spare_reg;
	logic         spare_valid_reg;
	logic         push;
	logic         pop;

	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_data        <= '0;
			out_valid       <= 1'b0;
			spare_reg       <= '0;
			spare_valid_reg <= 1'b0;
			in_ready        <= 1'b0;
		end else begin
			if (pop) begin
				if (spare_valid_reg) begin
					out_data        <= spare_reg;
					out_valid       <= 1'b1;
					spare_reg       <= in_data;
					spare_valid_reg <= push;
				end else begin
					out_data  <= in_data;
					out_valid <= push;
				end
			end else if (push) begin
				if (!out_valid) begin
					out_data  <= in_data;
					out_valid <= 1'b1;
				end else begin
					spare_reg       <= in_data;
					spare_valid_reg <= 1'b1;
				end
			end
			// Full when both entries hold data after this cycle
			in_ready <= !((out_valid | push) & (spare_valid_reg | (push & out_valid & !pop))
				& !(pop & !push & spare_valid_reg) | (spare_valid_reg & !pop));
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module lsp_slave (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Link
	lsp_if.dev                      link,
	// Transmit stream from user
	input  wire lsp_pkg::lsp_byte_t tx_data,
	input  wire logic               tx_valid,
	output logic                    tx_ready,
	// Receive stream to user
	output lsp_pkg::lsp_byte_t      rx_data,
	output logic                    rx_valid,
	input  wire logic               rx_ready,
	// Status
	input  wire logic               rx_full_irq_enable,
	input  wire logic               tx_empty_irq_enable,
	output logic                    rx_buffer_full_flag,
	output logic                    tx_buffer_empty_flag
);
	import lsp_pkg::*;

	lsp_slv_state_t state_reg;
	logic [2:0]     sclk_sync_reg;
	logic [1:0]     ss_sync_reg;
	logic [1:0]     mosi_sync_reg;
	logic           sclk_rise;
	logic           ss_s;
	logic           mosi_s;
	logic           abandon;
	logic [3:0]     edge_reg;
	logic           rw_reg;
	logic           addr_reg;
	logic           stale_reg;
	logic           miso_reg;
	logic           status_reg;
	lsp_byte_t      shift_reg;
	lsp_byte_t      status_byte;
	lsp_byte_t      load_byte;
	lsp_byte_t      tx_head;
	logic           tx_head_valid;
	logic           tx_pop_reg;
	logic           rx_room;
	logic           rx_push_reg;

	function automatic logic edge_is(input logic [3:0] e, input int n);
		return e == 4'(n);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Link synchronisers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sclk_sync_reg <= 3'h0;
			ss_sync_reg   <= 2'h0;
			mosi_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
			ss_sync_reg   <= {ss_sync_reg[0], link.ss};
			mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
		end
	end

	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign ss_s      = ss_sync_reg[1];
	assign mosi_s    = mosi_sync_reg[1];
	assign abandon   = (state_reg != LSP_S_IDLE) & !ss_s;

	////////////////////////////////////////////////////////////////////////////
	// Status byte and first byte of the data phase
	always_comb begin
		status_byte                = `LSP_ST_RESET;
		status_byte[`LSP_ST_RXF]  = !rx_room;
		status_byte[`LSP_ST_TXE]  = !tx_head_valid;
		status_byte[`LSP_ST_RXIE] = rx_full_irq_enable;
		status_byte[`LSP_ST_TXIE] = tx_empty_irq_enable;
		load_byte                  = mosi_s ? status_byte : tx_head;
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence control
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= LSP_S_IDLE;
			edge_reg  <= 4'h0;
			rw_reg    <= 1'b0;
			addr_reg  <= 1'b0;
		end else if (abandon) begin
			state_reg <= LSP_S_IDLE;
		end else if (sclk_rise) begin
			case (state_reg)
				LSP_S_IDLE: begin
					if (ss_s & mosi_s) begin
						state_reg <= LSP_S_SETUP;
						edge_reg  <= 4'h1;
					end
				end
				LSP_S_SETUP: begin
					edge_reg <= edge_reg + 4'h1;
					if (edge_is(edge_reg, `LSP_EDGE_RW)) begin
						rw_reg <= mosi_s;
					end else begin
						addr_reg  <= mosi_s;
						state_reg <= LSP_S_XFER;
					end
				end
				LSP_S_XFER: begin
					edge_reg <= edge_reg + 4'h1;
					if (edge_is(edge_reg, `LSP_EDGE_STATUS)) begin
						state_reg <= LSP_S_IDLE;
					end
				end
				default: state_reg <= LSP_S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data shifting and status bit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			shift_reg  <= 8'h00;
			miso_reg   <= 1'b0;
			stale_reg  <= 1'b0;
			status_reg <= 1'b0;
		end else if (abandon) begin
			miso_reg <= 1'b0;
		end else if (sclk_rise) begin
			if (state_reg == LSP_S_SETUP && edge_is(edge_reg, `LSP_EDGE_ADDR)) begin
				shift_reg <= load_byte;
				stale_reg <= !mosi_s & !tx_head_valid;
				miso_reg  <= rw_reg & load_byte[7];
			end else if (state_reg == LSP_S_XFER && edge_reg < 4'(`LSP_EDGE_DATA_LAST)) begin
				shift_reg <= {shift_reg[6:0], mosi_s};
				miso_reg  <= rw_reg & shift_reg[6];
			end else if (state_reg == LSP_S_XFER && edge_is(edge_reg, `LSP_EDGE_DATA_LAST)) begin
				// Last data bit in; status must stand before the twelfth edge
				shift_reg <= {shift_reg[6:0], mosi_s};
				// Read: stale flag, status read always zero; write: room test, address set always one
				if (rw_reg) begin
					status_reg <= !addr_reg & stale_reg;
					miso_reg   <= !addr_reg & stale_reg;
				end else begin
					status_reg <= addr_reg | !rx_room;
					miso_reg   <= addr_reg | !rx_room;
				end
			end else begin
				miso_reg <= 1'b0;
			end
		end
	end

	assign link.miso = miso_reg;

	////////////////////////////////////////////////////////////////////////////
	// Commit on the twelfth edge while select is still high
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_pop_reg  <= 1'b0;
			rx_push_reg <= 1'b0;
		end else begin
			tx_pop_reg <= sclk_rise & ss_s & (state_reg == LSP_S_XFER)
				& edge_is(edge_reg, `LSP_EDGE_STATUS) & rw_reg & !addr_reg & !status_reg;
			rx_push_reg <= sclk_rise & ss_s & (state_reg == LSP_S_XFER)
				& edge_is(edge_reg, `LSP_EDGE_STATUS) & !rw_reg & !addr_reg & !status_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_buffer_full_flag  <= 1'b0;
			tx_buffer_empty_flag <= 1'b1;
		end else begin
			rx_buffer_full_flag  <= !rx_room;
			tx_buffer_empty_flag <= !tx_head_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Buffers
	lsp_buf2 #(.W(8)) u_tx_buf (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (tx_head),
		.out_valid (tx_head_valid),
		.out_ready (tx_pop_reg)
	);

	lsp_buf2 #(.W(8)) u_rx_buf (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_data   (shift_reg),
		.in_valid  (rx_push_reg),
		.in_ready  (rx_room),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);
endmodule

// file: core/lsp_master.sv
// Master end of the legacy serial link: makes SCLK, runs one command at a time.
// Assumes lsp_buf2 from the slave file; the user repeats rejected or stale commands.
`include "lsp_regs.svh"

module lsp_master (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Link
	lsp_if.host                     link,
	// Command
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  wire logic               cmd_read,
	input  wire logic               cmd_status_sel,
	input  wire lsp_pkg::lsp_byte_t cmd_wdata,
	// Response
	output lsp_pkg::lsp_byte_t      rsp_data,
	output logic                    rsp_status,
	output logic                    rsp_valid,
	input  wire logic               rsp_ready
);
	import lsp_pkg::*;

	localparam logic [3:0] HALF = 4'(`LSP_SCLK_HALF);
	localparam logic [3:0] LAST = 4'(2 * `LSP_SCLK_HALF - 1);

	lsp_mst_state_t state_reg;
	logic [1:0]     miso_sync_reg;
	logic [3:0]     div_reg;
	logic [3:0]     edge_reg;
	logic [10:0]    out_reg;
	lsp_byte_t      in_reg;
	logic           sclk_reg;
	logic           ss_reg;
	logic           mosi_reg;
	logic           push_reg;
	logic [8:0]     push_data_reg;
	logic           rsp_room;
	logic [8:0]     rsp_word;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			miso_sync_reg <= 2'h0;
		end else begin
			miso_sync_reg <= {miso_sync_reg[0], link.miso};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock divider and bit sequence
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg     <= LSP_M_IDLE;
			div_reg       <= 4'h0;
			edge_reg      <= 4'h0;
			out_reg       <= 11'h000;
			in_reg        <= 8'h00;
			sclk_reg      <= 1'b0;
			ss_reg        <= 1'b0;
			mosi_reg      <= 1'b0;
			cmd_ready     <= 1'b0;
			push_reg      <= 1'b0;
			push_data_reg <= 9'h000;
		end else begin
			push_reg <= 1'b0;
			case (state_reg)
				LSP_M_IDLE: begin
					if (cmd_valid & cmd_ready) begin
						cmd_ready <= 1'b0;
						ss_reg    <= 1'b1;
						mosi_reg  <= 1'b1;
						out_reg   <= {cmd_read, cmd_status_sel, cmd_wdata, 1'b0};
						edge_reg  <= 4'h0;
						div_reg   <= 4'h1;
						state_reg <= LSP_M_RUN;
					end else begin
						cmd_ready <= rsp_room;
					end
				end
				LSP_M_RUN: begin
					div_reg <= (div_reg == LAST) ? 4'h0 : div_reg + 4'h1;
					if (div_reg == 4'h0) begin
						sclk_reg <= 1'b1;
						edge_reg <= edge_reg + 4'h1;
						if (edge_reg >= 4'(`LSP_EDGE_DATA_FIRST)
							&& edge_reg <= 4'(`LSP_EDGE_DATA_LAST)) begin
							in_reg <= {in_reg[6:0], miso_sync_reg[1]};
						end
						if (edge_reg == 4'(`LSP_EDGE_STATUS)) begin
							push_reg      <= 1'b1;
							push_data_reg <= {miso_sync_reg[1], in_reg};
						end
					end
					if (div_reg == 4'(`LSP_LAUNCH_DLY) && edge_reg != 4'h0) begin
						if (edge_reg == 4'(`LSP_XFER_EDGES)) begin
							ss_reg   <= 1'b0;
							mosi_reg <= 1'b0;
						end else begin
							mosi_reg <= out_reg[10];
							out_reg  <= {out_reg[9:0], 1'b0};
						end
					end
					if (div_reg == HALF) begin
						sclk_reg <= 1'b0;
					end
					if (div_reg == LAST && edge_reg == 4'(`LSP_XFER_EDGES)) begin
						div_reg   <= 4'h0;
						state_reg <= LSP_M_GAP;
					end
				end
				LSP_M_GAP: begin
					div_reg <= div_reg + 4'h1;
					if (div_reg == LAST) begin
						state_reg <= LSP_M_IDLE;
					end
				end
				default: state_reg <= LSP_M_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.ss   = ss_reg;
	assign link.mosi = mosi_reg;

	////////////////////////////////////////////////////////////////////////////
	// Response buffer
	lsp_buf2 #(.W(9)) u_rsp_buf (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_data   (push_data_reg),
		.in_valid  (push_reg),
		.in_ready  (rsp_room),
		.out_data  (rsp_word),
		.out_valid (rsp_valid),
		.out_ready (rsp_ready)
	);

	assign rsp_data   = rsp_word[7:0];
	assign rsp_status = rsp_word[8];
endmodule

// file: test/lsp_link_checker.sv
// Assertions on the four wires between master end and slave end.
// Assumes the bench instantiates it beside the link interface.
module lsp_link_checker (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Link
	input  wire logic sclk,
	input  wire logic ss,
	input  wire logic mosi,
	input  wire logic miso
);
	logic       sclk_reg;
	logic [3:0] rise_cnt_reg;
	logic       rw_reg;
	logic       adr_reg;
	wire        rise = sclk && !sclk_reg;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////
	// Link clock edges seen on ref_clk
	always_ff @(posedge ref_clk) begin
		sclk_reg <= rst_n ? sclk : 1'b0;
	end

	// Rising edges counted inside a frame
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !ss)
			rise_cnt_reg <= 4'h0;
		else if (rise)
			rise_cnt_reg <= rise_cnt_reg + 4'h1;
	end

	// Setup bits of the current frame
	always_ff @(posedge ref_clk) begin
		if (rise && rise_cnt_reg == 4'h1)
			rw_reg <= mosi;
		if (rise && rise_cnt_reg == 4'h2)
			adr_reg <= mosi;
	end

	////////////////////////////////////////
	sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase wrong");
	sclk_low_a: assert property ($fell(sclk) && ss |-> !sclk [*4] ##1 sclk)
		else $error("link clock low phase wrong in frame");
	frame_len_a: assert property ($fell(ss) |-> rise_cnt_reg == 4'hC)
		else $error("select dropped before twelve edges");
	ss_gap_a: assert property ($fell(ss) |-> !ss [*8])
		else $error("select gap shorter than one link period");
	start_bit_a: assert property (rise && ss && rise_cnt_reg == 4'h0 |-> mosi)
		else $error("first edge without start bit");
	start_lead_a: assert property ($rose(ss) |-> mosi ##[1:10] rise)
		else $error("start not followed by a link edge");
	stat_zero_a: assert property (rise && ss && rise_cnt_reg == 4'hB && rw_reg && adr_reg
		|-> !miso)
		else $error("status read trailing bit not zero");
	bad_write_a: assert property (rise && ss && rise_cnt_reg == 4'hB && !rw_reg && adr_reg
		|-> miso)
		else $error("write with address set not refused");
	idle_miso_a: assert property (!ss [*8] |-> !miso)
		else $error("slave output not idle outside frame");
endmodule

// file: test/tb_legacy_spi_slave_protocol.sv
// Self-checking bench: master end and slave end joined through the link.
// Assumes design files, interface and link checker are compiled first.
module tb_legacy_spi_slave_protocol;
	timeunit 1ns;
	timeprecision 1ns;
	import lsp_pkg::*;

	logic       ref_clk, rst_n, cmd_valid, cmd_ready, cmd_read, cmd_status_sel;
	logic       rsp_status, rsp_valid, rsp_ready, tx_valid, tx_ready, rx_valid, rx_ready;
	logic       rx_full_irq_enable, tx_empty_irq_enable;
	logic       rx_buffer_full_flag, tx_buffer_empty_flag;
	lsp_byte_t  cmd_wdata, rsp_data, tx_data, rx_data, w0, w1, w2;
	logic [9:0] exp_q[$];
	logic [9:0] exp_e;
	lsp_byte_t  rx_q[$];
	int         failures, total_checks, tx_cnt, rx_cnt;

	lsp_if lsp_if_i ();
	lsp_master lsp_master_i (.ref_clk, .rst_n, .link(lsp_if_i), .cmd_valid, .cmd_ready,
		.cmd_read, .cmd_status_sel, .cmd_wdata, .rsp_data, .rsp_status, .rsp_valid,
		.rsp_ready);
	lsp_slave lsp_slave_i (.ref_clk, .rst_n, .link(lsp_if_i), .tx_data, .tx_valid,
		.tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_full_irq_enable,
		.tx_empty_irq_enable, .rx_buffer_full_flag, .tx_buffer_empty_flag);
	lsp_link_checker lsp_link_checker_i (.ref_clk, .rst_n, .sclk(lsp_if_i.sclk),
		.ss(lsp_if_i.ss), .mosi(lsp_if_i.mosi), .miso(lsp_if_i.miso));

	always #50 ref_clk = ~ref_clk;

	////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(string name, lsp_byte_t exp, lsp_byte_t seen);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stall_out();
		failures++;
		$display("[FAIL] wait expected handshake seen none");
		complete_run();
	endtask

	task automatic step();
		@(posedge ref_clk);
		#2;
	endtask

	// Waits for responses and settled flags
	task automatic wait_idle();
		int n;
		n = 0;
		while ((exp_q.size() != 0 || (rx_ready && rx_q.size() != 0)) && n < 500) begin
			step();
			n++;
		end
		if (n >= 500)
			stall_out();
		repeat (8) step();
	endtask

	// One link command; expectation noted first
	task automatic cmd(logic rd, logic sel, lsp_byte_t wd, lsp_byte_t ed, logic est, logic cd);
		int n;
		n = 0;
		exp_q.push_back({cd, est, ed});
		step();
		cmd_read = rd;
		cmd_status_sel = sel;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 500);
		#2;
		cmd_valid = 1'b0;
		if (n >= 500)
			stall_out();
		wait_idle();
	endtask

	task automatic push_tx(lsp_byte_t d);
		int n;
		n = 0;
		step();
		tx_data = d;
		tx_valid = 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (tx_ready !== 1'b1 && n < 500);
		#2;
		tx_valid = 1'b0;
		tx_cnt++;
		if (n >= 500)
			stall_out();
	endtask

	task automatic wr(lsp_byte_t d);
		rx_q.push_back(d);
		rx_cnt++;
		cmd(1'b0, 1'b0, d, 8'h00, 1'b0, 1'b0);
	endtask

	task automatic stat();
		rx_full_irq_enable = 1'($urandom);
		tx_empty_irq_enable = 1'($urandom);
		cmd(1'b1, 1'b1, 8'h00, {2'b00, tx_empty_irq_enable, rx_full_irq_enable, 2'b00,
			tx_cnt == 0, rx_cnt == 2}, 1'b0, 1'b1);
		check("rx_full_flag", {7'h00, rx_cnt == 2}, {7'h00, rx_buffer_full_flag});
		check("tx_empty_flag", {7'h00, tx_cnt == 0}, {7'h00, tx_buffer_empty_flag});
	endtask

	////////////////////////////////////////
	// Response and receive stream monitor
	always @(posedge ref_clk) begin
		if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
			if (exp_q.size() == 0)
				check("rsp_extra", 8'h00, 8'hFF);
			else begin
				exp_e = exp_q.pop_front();
				check("rsp_status", {7'h00, exp_e[8]}, {7'h00, rsp_status});
				if (exp_e[9])
					check("rsp_data", exp_e[7:0], rsp_data);
			end
		end
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (rx_q.size() == 0)
				check("rx_extra", 8'h00, 8'hFF);
			else
				check("rx_data", rx_q.pop_front(), rx_data);
		end
	end

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		{cmd_valid, cmd_read, cmd_status_sel, tx_valid, rx_ready} = 5'h00;
		{rx_full_irq_enable, tx_empty_irq_enable} = 2'h0;
		{cmd_wdata, tx_data} = 16'h0000;
		rsp_ready = 1'b1;
		{failures, total_checks, tx_cnt, rx_cnt} = 128'h0;
		void'($urandom(34));
		repeat (6) @(posedge ref_clk);
		#2;
		rst_n = 1'b1;
		repeat (2) step();
		stat();
		cmd(1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
		cmd(1'b0, 1'b1, 8'hA5, 8'h00, 1'b1, 1'b0);
		w0 = 8'($urandom);
		w1 = 8'($urandom);
		push_tx(w0);
		push_tx(w1);
		stat();
		cmd(1'b1, 1'b0, 8'h00, w0, 1'b0, 1'b1);
		tx_cnt--;
		cmd(1'b1, 1'b0, 8'h00, w1, 1'b0, 1'b1);
		tx_cnt--;
		cmd(1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
		w0 = 8'($urandom);
		w1 = 8'($urandom);
		w2 = 8'($urandom);
		wr(w0);
		wr(w1);
		cmd(1'b0, 1'b0, w2, 8'h00, 1'b1, 1'b0);
		stat();
		rx_ready = 1'b1;
		wait_idle();
		rx_cnt = 0;
		wr(w2);
		stat();
		complete_run();
	end
endmodule
